// *** epa_pkg.sv ***
// epa_pkg: constants, codes and register map of the programming-mode access block
// assumes a 40 MHz clock and a 32-bit classic Wishbone register bus
package epa_pkg;

    // ==========================================
    // geometry
    localparam int ADDR_W   = 13;
    localparam int DATA_W   = 8;
    localparam int OPC_W    = 4;
    localparam int ID_AW    = 6;
    localparam int WB_AW    = 8;

    // ==========================================
    // operation codes
    typedef enum logic [3:0] {
        OPC_STANDBY  = 4'h0,
        OPC_READ     = 4'h1,
        OPC_UNLOCK   = 4'h2,
        OPC_WRITE    = 4'h3,
        OPC_LOCK     = 4'h4,
        OPC_ID_WRITE = 4'h5,
        OPC_LOCK_RD  = 4'h9,
        OPC_ID_READ  = 4'hA
    } epa_opc_t;

    // strobe sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_WAIT  = 4'h2,
        ST_DONE  = 4'h4,
        ST_ERASE = 4'h8
    } epa_state_t;

    // ==========================================
    // timing
    localparam int CLK_MHZ      = 40;
    localparam int WRITE_MIN_US = 10;
    localparam int OTHER_MIN_NS = 100;
    localparam int WRITE_CYC    = WRITE_MIN_US * CLK_MHZ;
    localparam int OTHER_CYC    = (OTHER_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int STB_CNT_W    = 9;
    localparam logic [STB_CNT_W-1:0] WRITE_CNT = STB_CNT_W'(WRITE_CYC);
    localparam logic [STB_CNT_W-1:0] OTHER_CNT = STB_CNT_W'(OTHER_CYC);

    // ==========================================
    // register map, byte addresses
    localparam logic [WB_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [WB_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [WB_AW-1:0] REG_ADDR   = 8'h08;
    localparam logic [WB_AW-1:0] REG_RDATA  = 8'h0C;

    // field positions
    localparam int CTRL_ERASE  = 0;
    localparam int CTRL_ENABLE = 1;
    localparam int STS_LOCK    = 0;
    localparam int STS_CELL    = 1;
    localparam int STS_MODE    = 2;
    localparam int STS_ERASING = 3;
    localparam int STS_REFUSED = 4;
    localparam int STS_STANDBY = 5;
    localparam int STS_OPC_LSB = 8;

    // values after reset, and the result byte of a write
    localparam logic              ENABLE_RST = 1'b1;
    localparam logic [ADDR_W-1:0] ADDR_RST   = 13'h0000;
    localparam logic [OPC_W-1:0]  OPC_RST    = 4'h0;
    localparam logic [DATA_W-1:0] RES_RST    = 8'h00;
    localparam logic [DATA_W-1:0] WR_RESULT  = 8'h00;

endpackage

// *** epa_mem.sv ***
// epa_mem: byte memory whose cells can only be cleared by writes, set by fill
// assumes one clock; read data registered, one cycle after the address
`timescale 1ns/1ps
module epa_mem #(
    parameter int AW = 13,
    parameter int DW = 8
) (
    // clock and enable
    input  wire logic          clk_i,
    input  wire logic          ce_i,
    // access port
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          we_i,
    input  wire logic          fill_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    // ==========================================
    // fill sets a cell blank, a write only clears bits
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (fill_i) begin
                mem_q[addr_i] <= '1;
            end else if (we_i) begin
                mem_q[addr_i] <= mem_q[addr_i] & wdata_i;
            end
            rdata_o <= mem_q[addr_i];
        end
    end

endmodule

// *** epa_rise.sv ***
// epa_rise: rising-edge pulse per bit of synchronous pin inputs
// assumes inputs already synchronous to clk_i
`timescale 1ns/1ps
module epa_rise #(
    parameter int W = 2
) (
    // clock, reset, enable
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic         ce_i,
    // levels in, pulses out
    input  wire logic [W-1:0] lvl_i,
    output logic      [W-1:0] rise_o
);

    logic [W-1:0] prev_reg;

    // ==========================================
    // one registered pulse per low-to-high change
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                prev_reg[i] <= 1'b0;
                rise_o[i]   <= 1'b0;
            end else if (ce_i) begin
                prev_reg[i] <= lvl_i[i];
                rise_o[i]   <= lvl_i[i] & ~prev_reg[i];
            end
        end
    end

endmodule

// *** epa_top.sv ***
// epa_top: programming-mode access to the program memory through control pins
// assumes pins synchronous to clk_i (40 MHz) and a classic Wishbone master
`timescale 1ns/1ps
module epa_top (
    // clock, reset, enable
    input  wire logic                           clk_i,
    input  wire logic                           reset_i,
    input  wire logic                           ce_i,
    // mode selection pins
    input  wire logic                           chip_reset_pin_i,
    input  wire logic                           test_pin_i,
    // programming control pins
    input  wire logic                           strobe_n_i,
    input  wire logic                           addr_clear_n_i,
    input  wire logic                           opcode_clear_i,
    input  wire logic                           addr_step_i,
    input  wire logic                           opcode_step_i,
    // program data port
    input  wire logic [epa_pkg::DATA_W-1:0]     program_data_port_i,
    output logic      [epa_pkg::DATA_W-1:0]     program_data_port_o,
    output logic                                program_data_port_oe_o,
    // status pins
    output logic                                standby_o,
    output logic                                prog_mode_o,
    // wishbone slave
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [epa_pkg::WB_AW-1:0]      wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [31:0]                    wb_dat_i,
    output logic      [31:0]                    wb_dat_o,
    output logic                                wb_ack_o
);
    import epa_pkg::*;

    // ==========================================
    // state
    logic                 mode_reg;
    logic                 enable_reg;
    logic [ADDR_W-1:0]    addr_reg;
    logic [OPC_W-1:0]     opcode_reg;
    logic                 lock_status_reg;
    logic                 lock_cell_reg = 1'b1; // nonvolatile, blank at power-up
    logic                 refused_reg;
    logic [DATA_W-1:0]    result_reg;
    logic [ADDR_W-1:0]    erase_reg;
    logic [STB_CNT_W-1:0] cnt_reg;
    epa_state_t           state_reg;

    // combinational
    logic [1:0]           step_rise;
    logic                 addr_clear;
    logic                 exec;
    logic                 permit;
    logic                 refuse_evt;
    logic                 id_hit;
    logic                 is_write;
    logic [STB_CNT_W-1:0] need_cnt;
    logic                 erasing;
    logic                 erase_last;
    logic [ADDR_W-1:0]    mem_addr;
    logic [DATA_W-1:0]    main_rdata;
    logic [DATA_W-1:0]    id_rdata;
    logic                 main_we;
    logic                 id_we;
    logic                 wb_hit;
    logic                 wr_fire;
    logic [31:0]          status_word;
    epa_opc_t             opc;

    // ==========================================
    // pin edge detection for the step inputs
    epa_rise #(
        .W(2)
    ) u_rise (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .lvl_i   ({opcode_step_i, addr_step_i}),
        .rise_o  (step_rise)
    );

    // ==========================================
    // mode entry, also steered by software enable
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_reg <= 1'b0;
        end else if (ce_i) begin
            mode_reg <= ~chip_reset_pin_i & ~test_pin_i & enable_reg;
        end
    end

    assign addr_clear = mode_reg & ~addr_clear_n_i;
    assign opc        = epa_opc_t'(opcode_reg);
    assign erasing    = (state_reg == ST_ERASE);
    assign erase_last = &erase_reg;

    // ==========================================
    // memory address register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_reg <= ADDR_RST;
        end else if (ce_i) begin
            if (addr_clear) begin
                addr_reg <= ADDR_RST;
            end else if (mode_reg && step_rise[0]) begin
                addr_reg <= addr_reg + 1'b1;
            end
        end
    end

    // ==========================================
    // operation-code register, four bits
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            opcode_reg <= OPC_RST;
        end else if (ce_i) begin
            if (mode_reg && opcode_clear_i) begin
                opcode_reg <= OPC_RST;
            end else if (mode_reg && step_rise[1]) begin
                opcode_reg <= opcode_reg + 1'b1;
            end
        end
    end

    // ==========================================
    // low-time needed before an operation fires
    assign is_write = (opc == OPC_WRITE) || (opc == OPC_ID_WRITE);
    assign need_cnt = is_write ? WRITE_CNT - 9'h001 : OTHER_CNT - 9'h001;

    // fires once per strobe pulse, after the minimum low time
    assign exec = (state_reg == ST_WAIT) && mode_reg && !strobe_n_i
                  && (cnt_reg >= need_cnt);

    // identification area is the bottom 64 addresses
    assign id_hit = (addr_reg[ADDR_W-1:ID_AW] == '0);

    // ==========================================
    // permission decode against lock status and lock cell
    always_comb begin
        permit = 1'b0;
        unique case (opc)
            OPC_STANDBY:  permit = 1'b0;
            OPC_READ:     permit = 1'b1;
            OPC_LOCK_RD:  permit = 1'b1;
            OPC_ID_READ:  permit = id_hit;
            OPC_UNLOCK:   permit = lock_cell_reg;
            OPC_WRITE:    permit = lock_status_reg;
            OPC_LOCK:     permit = lock_status_reg;
            OPC_ID_WRITE: permit = lock_status_reg & id_hit;
            default:      permit = 1'b0;
        endcase
    end

    // anything not permitted is dropped and flagged, except standby, which is dropped without a flag
    assign refuse_evt = exec && !permit && (opc != OPC_STANDBY);

    // ==========================================
    // strobe sequencer and erase walk
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
            erase_reg <= ADDR_RST;
        end else if (ce_i) begin
            unique case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= '0;
                    if (wr_fire && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_ERASE]) begin
                        state_reg <= ST_ERASE;
                        erase_reg <= ADDR_RST;
                    end else if (mode_reg && !strobe_n_i) begin
                        state_reg <= ST_WAIT;
                        cnt_reg   <= 9'h001;
                    end
                end
                ST_WAIT: begin
                    if (!mode_reg || strobe_n_i) begin
                        state_reg <= ST_IDLE;
                    end else if (exec) begin
                        state_reg <= ST_DONE;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_DONE: begin
                    if (!mode_reg || strobe_n_i) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_ERASE: begin
                    erase_reg <= erase_reg + 1'b1;
                    if (erase_last) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // memory write strobes
    assign main_we  = exec && permit && (opc == OPC_WRITE);
    assign id_we    = exec && permit && (opc == OPC_ID_WRITE);
    assign mem_addr = erasing ? erase_reg : addr_reg;

    // main program memory, 8 Kbyte
    epa_mem #(
        .AW(ADDR_W),
        .DW(DATA_W)
    ) u_main (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .addr_i  (mem_addr),
        .we_i    (main_we),
        .fill_i  (erasing),
        .wdata_i (program_data_port_i),
        .rdata_o (main_rdata)
    );

    // identification area, 64 bytes
    epa_mem #(
        .AW(ID_AW),
        .DW(DATA_W)
    ) u_id (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .addr_i  (mem_addr[ID_AW-1:0]),
        .we_i    (id_we),
        .fill_i  (erasing),
        .wdata_i (program_data_port_i),
        .rdata_o (id_rdata)
    );

    // ==========================================
    // volatile lock status
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lock_status_reg <= 1'b0;
        end else if (ce_i) begin
            if (addr_clear) begin
                lock_status_reg <= 1'b0;
            end else if (exec && permit && opc == OPC_UNLOCK) begin
                lock_status_reg <= 1'b1;
            end else if (exec && permit && opc == OPC_LOCK) begin
                lock_status_reg <= 1'b0;
            end
        end
    end

    // ==========================================
    // permanent lock cell, untouched by reset
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (erasing && erase_last) begin
                lock_cell_reg <= 1'b1;
            end else if (exec && permit && opc == OPC_LOCK) begin
                lock_cell_reg <= 1'b0;
            end
        end
    end

    // ==========================================
    // result latch for the data port
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            result_reg <= RES_RST;
        end else if (ce_i && exec && permit) begin
            unique case (opc)
                OPC_READ:     result_reg <= main_rdata;
                OPC_ID_READ:  result_reg <= id_rdata;
                OPC_UNLOCK:   result_reg <= {7'h00, lock_status_reg};
                OPC_LOCK_RD:  result_reg <= {7'h00, lock_status_reg};
                OPC_WRITE:    result_reg <= WR_RESULT;
                OPC_ID_WRITE: result_reg <= WR_RESULT;
                default:      result_reg <= result_reg;
            endcase
        end
    end

    // ==========================================
    // pin outputs, all registered
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            program_data_port_o    <= RES_RST;
            program_data_port_oe_o <= 1'b0;
            standby_o              <= 1'b1;
            prog_mode_o            <= 1'b0;
        end else if (ce_i) begin
            program_data_port_o    <= result_reg;
            program_data_port_oe_o <= mode_reg & opcode_clear_i;
            standby_o              <= ~mode_reg | strobe_n_i | (opcode_reg == OPC_RST);
            prog_mode_o            <= mode_reg;
        end
    end

    // ==========================================
    // wishbone handshake, one wait cycle then ack
    assign wb_hit  = wb_cyc_i & wb_stb_i;
    assign wr_fire = wb_hit & wb_we_i & wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= wb_hit & ~wb_ack_o;
        end
    end

    // status word gathers the block's own state
    always_comb begin
        status_word                                 = 32'h0000_0000;
        status_word[STS_LOCK]                       = lock_status_reg;
        status_word[STS_CELL]                       = lock_cell_reg;
        status_word[STS_MODE]                       = mode_reg;
        status_word[STS_ERASING]                    = erasing;
        status_word[STS_REFUSED]                    = refused_reg;
        status_word[STS_STANDBY]                    = standby_o;
        status_word[STS_OPC_LSB +: OPC_W]           = opcode_reg;
    end

    // read data, captured with the ack, zero when unmapped
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i && wb_hit && !wb_ack_o) begin
            unique case (wb_adr_i)
                REG_CTRL:   wb_dat_o <= {30'h0000_0000, enable_reg, erasing};
                REG_STATUS: wb_dat_o <= status_word;
                REG_ADDR:   wb_dat_o <= {19'h00000, addr_reg};
                REG_RDATA:  wb_dat_o <= {24'h000000, result_reg};
                default:    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================
    // control register, written at the ack edge
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            enable_reg <= ENABLE_RST;
        end else if (ce_i && wr_fire && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            enable_reg <= wb_dat_i[CTRL_ENABLE];
        end
    end

    // sticky refusal flag, set wins over clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            refused_reg <= 1'b0;
        end else if (ce_i) begin
            if (refuse_evt) begin
                refused_reg <= 1'b1;
            end else if (wr_fire && wb_adr_i == REG_STATUS && wb_sel_i[0] && wb_dat_i[STS_REFUSED]) begin
                refused_reg <= 1'b0;
            end
        end
    end

endmodule

// *** epa_top_sva.sv ***
// epa_top_sva: bus handshake and pin timing checks on the access block
// assumes a bind onto epa_top, pins synchronous to clk_i
`timescale 1ns/1ps
module epa_top_sva (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       reset_i,
    // pins
    input  wire logic                       chip_reset_pin_i,
    input  wire logic                       test_pin_i,
    input  wire logic                       strobe_n_i,
    input  wire logic                       opcode_clear_i,
    input  wire logic [epa_pkg::DATA_W-1:0] program_data_port_o,
    input  wire logic                       program_data_port_oe_o,
    input  wire logic                       standby_o,
    input  wire logic                       prog_mode_o,
    // wishbone
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [31:0]                wb_dat_o,
    input  wire logic                       wb_ack_o
);
    import epa_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ==========================================
    // properties
    property p_ack_one;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack missing after request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_dat_hold;
        !wb_ack_o |-> $stable(wb_dat_o);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
    property p_mode_off;
        (chip_reset_pin_i || test_pin_i) [*3] |-> !prog_mode_o;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("program mode with pin high");
    property p_oe_on;
        (opcode_clear_i && prog_mode_o) ##1 prog_mode_o |-> program_data_port_oe_o;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("port not driven under opcode clear");
    property p_oe_off;
        !opcode_clear_i |=> !program_data_port_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("port driven without opcode clear");
    property p_result_hold;
        strobe_n_i [*4] |-> $stable(program_data_port_o);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved without strobe");
    property p_standby;
        strobe_n_i [*4] |-> standby_o;
    endproperty
    a_standby: assert property (p_standby) else $error("no standby with strobe high");
    c_write_ack: cover property (wb_ack_o && wb_we_i);
    c_port_out: cover property (program_data_port_oe_o);
    c_active: cover property (!standby_o);
endmodule

bind epa_top epa_top_sva epa_top_sva_i (.clk_i, .reset_i, .chip_reset_pin_i, .test_pin_i, .strobe_n_i,
    .opcode_clear_i, .program_data_port_o, .program_data_port_oe_o, .standby_o, .prog_mode_o,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o);

// *** epa_prog.sv ***
// epa_prog: behavioural programmer driving control pins and data port
// assumes the bench resolves the data wire and feeds it back on port_i
`timescale 1ns/1ps
module epa_prog (
    // clock and wire feedback
    input  wire logic                       clk_i,
    input  wire logic [epa_pkg::DATA_W-1:0] port_i,
    // pins towards the device
    output logic                            reset_pin_o,
    output logic                            test_pin_o,
    output logic                            strobe_n_o,
    output logic                            addr_clear_n_o,
    output logic                            opcode_clear_o,
    output logic                            addr_step_o,
    output logic                            opcode_step_o,
    output logic [epa_pkg::DATA_W-1:0]      data_o
);
    import epa_pkg::*;
    // ==========================================
    // idle pin levels
    initial begin
        {reset_pin_o, test_pin_o, strobe_n_o, addr_clear_n_o} = 4'hF;
        {opcode_clear_o, addr_step_o, opcode_step_o} = 3'h0;
        data_o = 8'h00;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // both mode pins low selects programming
    task automatic enter;
        reset_pin_o <= 1'b0;
        test_pin_o <= 1'b0;
        wt(4);
    endtask
    task automatic aclr;
        addr_clear_n_o <= 1'b0;
        wt(3);
        addr_clear_n_o <= 1'b1;
        wt(3);
    endtask
    task automatic astep(input int n);
        repeat (n) begin
            addr_step_o <= 1'b1;
            wt(2);
            addr_step_o <= 1'b0;
            wt(2);
        end
    endtask
    // clear, step the code in, one low strobe with data held
    task automatic op(input logic [3:0] code, input logic [7:0] d, input int low);
        opcode_clear_o <= 1'b1;
        wt(3);
        opcode_clear_o <= 1'b0;
        data_o <= d;
        wt(2);
        for (int i = 0; i < code; i++) begin
            opcode_step_o <= 1'b1;
            wt(2);
            opcode_step_o <= 1'b0;
            wt(2);
        end
        wt(2);
        strobe_n_o <= 1'b0;
        wt(low);
        strobe_n_o <= 1'b1;
        data_o <= ~d;
        wt(4);
    endtask
    // raising opcode clear, left high, brings the result out
    task automatic result(output logic [7:0] r);
        opcode_clear_o <= 1'b1;
        wt(4);
        r = port_i;
    endtask
endmodule

// *** tb_eprom_program_mode_access.sv ***
// tb_eprom_program_mode_access: self-checking bench for epa_top
// assumes epa_prog as pin partner and a classic wishbone master here
`timescale 1ns/1ps
module tb_eprom_program_mode_access;
    import epa_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0, wb_dat_o, r;
    logic wb_ack_o, strobe_n, aclr_n, oclr, astep, ostep, rpin, tpin, oe, standby, mode;
    logic [7:0] pd_o, pd_prog, pd_wire, v;
    int failures = 0, n_compared = 0;
    assign pd_wire = oe ? pd_o : pd_prog;
    always #12.5 clk = ~clk;
    epa_top epa_top_i (.clk_i(clk), .reset_i(reset), .ce_i(1'b1), .chip_reset_pin_i(rpin), .test_pin_i(tpin),
        .strobe_n_i(strobe_n), .addr_clear_n_i(aclr_n), .opcode_clear_i(oclr), .addr_step_i(astep),
        .opcode_step_i(ostep), .program_data_port_i(pd_wire), .program_data_port_o(pd_o),
        .program_data_port_oe_o(oe), .standby_o(standby), .prog_mode_o(mode), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    epa_prog epa_prog_i (.clk_i(clk), .port_i(pd_wire), .reset_pin_o(rpin), .test_pin_o(tpin),
        .strobe_n_o(strobe_n), .addr_clear_n_o(aclr_n), .opcode_clear_o(oclr), .addr_step_o(astep),
        .opcode_step_o(ostep), .data_o(pd_prog));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one classic cycle, held until ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, we, a, d};
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) failures++;
        r = wb_dat_o;
        {wb_cyc, wb_stb} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic t_reset;
        chk("standby", 32'(standby), 32'h1);
        chk("mode", 32'(mode), 32'h0);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("cell", 32'(r[STS_CELL]), 32'h1);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", r, 32'h0);
    endtask
    task automatic t_erase;
        wb(1'b1, REG_CTRL, 32'h3);
        for (int n = 0; n < 5000; n++) begin
            wb(1'b0, REG_STATUS, 32'h0);
            if (r[STS_ERASING] === 1'b0) break;
        end
        chk("erased", 32'(r[STS_ERASING]), 32'h0);
    endtask
    task automatic t_mode;
        epa_prog_i.enter();
        chk("mode", 32'(mode), 32'h1);
        epa_prog_i.aclr();
        epa_prog_i.astep(5);
        wb(1'b0, REG_ADDR, 32'h0);
        chk("addr", r, 32'h5);
    endtask
    task automatic t_locked;
        epa_prog_i.op(OPC_WRITE, 8'h3C, 410);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("refused", 32'(r[STS_REFUSED]), 32'h1);
        wb(1'b1, REG_STATUS, 32'h10);
        epa_prog_i.op(OPC_READ, 8'h00, 6);
        epa_prog_i.result(v);
        chk("blank", 32'(v), 32'hFF);
    endtask
    task automatic t_write;
        epa_prog_i.op(OPC_UNLOCK, 8'h00, 4);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("unlock", 32'(r[STS_LOCK]), 32'h1);
        epa_prog_i.op(OPC_WRITE, 8'hA5, 400);
        epa_prog_i.result(v);
        chk("oe", 32'(oe), 32'h1);
        epa_prog_i.op(OPC_READ, 8'h00, 6);
        epa_prog_i.result(v);
        chk("byte", 32'(v), 32'hA5);
        epa_prog_i.op(OPC_WRITE, 8'h5A, 410);
        epa_prog_i.op(OPC_READ, 8'h00, 6);
        epa_prog_i.result(v);
        chk("clear only", 32'(v), 32'h00);
        epa_prog_i.op(OPC_LOCK_RD, 8'h00, 6);
        epa_prog_i.result(v);
        chk("status byte", 32'(v), 32'h01);
    endtask
    task automatic t_id;
        epa_prog_i.aclr();
        wb(1'b0, REG_STATUS, 32'h0);
        chk("relock", 32'(r[STS_LOCK]), 32'h0);
        wb(1'b0, REG_ADDR, 32'h0);
        chk("addr zero", r, 32'h0);
        epa_prog_i.op(OPC_ID_READ, 8'h00, 6);
        epa_prog_i.result(v);
        chk("id", 32'(v), 32'hFF);
    endtask
    task automatic t_lock;
        epa_prog_i.op(OPC_UNLOCK, 8'h00, 6);
        epa_prog_i.op(OPC_LOCK, 8'h00, 6);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("locked", 32'(r[1:0]), 32'h0);
        epa_prog_i.op(OPC_UNLOCK, 8'h00, 6);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("stay locked", 32'(r[STS_LOCK]), 32'h0);
        epa_prog_i.op(OPC_WRITE, 8'h3C, 410);
        epa_prog_i.op(OPC_READ, 8'h00, 6);
        epa_prog_i.result(v);
        chk("no write", 32'(v), 32'hFF);
    endtask
    // watchdog
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_erase();
        t_mode();
        t_locked();
        t_write();
        t_id();
        t_lock();
        report_and_stop();
    end
endmodule
